// ### dv/protocol_select_and_signal_level_code_capture_tb.sv
// Self-checking bench for protocol decode, level capture and clock output
`timescale 1ns/10ps
module protocol_select_and_signal_level_code_capture_tb;
  import psr_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0] main_c = 3'h0, aux_c = 3'h0, ext_c = 3'h0;
  logic rx_on = 1'b0, pen = 1'b1, pen2 = 1'b0;
  logic bco, fe, init_o, act_o, pl, txs;
  logic [1:0] rs;
  psr_op_t op;
  psr_proto_t fam;
  int miscompares = 0, tests_run = 0, tx_seen = 0, pl_seen = 0, n;

  psr_top #(.SLOW_HALF(4)) u_psr_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .main_level_code(main_c), .aux_level_code(aux_c),
    .main_rf_input_code(ext_c), .rx_active(rx_on), .primary_power_enable(pen),
    .secondary_power_enable(pen2), .buffered_clock_output(bco), .framing_enable(fe),
    .op_mode(op), .proto_family(fam), .rate_sel(rs), .initiator(init_o),
    .active_mode(act_o), .preset_load(pl), .tx_start(txs));
  psr_host_model u_psr_host_model (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  // 250 MHz clock
  initial
  begin
    forever #2 pclk = ~pclk;
  end

  // Pulse counters; one-cycle pulses would be missed by polling
  always @(posedge pclk)
  begin
    if (txs === 1'b1) tx_seen++;
    if (pl === 1'b1) pl_seen++;
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task results();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Write a protocol code and compare the decoded outputs
  task dec(input logic [7:0] c, input psr_op_t eo, input psr_proto_t ef, input logic ee);
    u_psr_host_model.wr(ADDR_PROTO, c);
    repeat (2) @(posedge pclk);
    chk("framing", {31'h0, ee}, {31'h0, fe});
    chk("family", {29'h0, ef}, {29'h0, fam});
    chk("op_mode", {30'h0, eo}, {30'h0, op});
  endtask

  // Count output toggles over 16 cycles
  task tog(input logic [7:0] m, input int e);
    logic last;
    u_psr_host_model.wr(ADDR_MOD_CLK, m);
    repeat (8) @(negedge pclk);
    last = bco;
    n = 0;
    repeat (16)
    begin
      @(negedge pclk);
      if (bco !== last) n++;
      last = bco;
    end
    chk("clk toggles", e, n);
  endtask

  task lvl(input logic [7:0] e);
    u_psr_host_model.rd(ADDR_LEVEL);
    chk("level", {24'h0, e}, u_psr_host_model.q);
  endtask

  // Watchdog sized well beyond four measurement pauses
  initial
  begin
    repeat (90000) @(posedge pclk);
    miscompares++;
    results();
  end

  // Main sequence
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    u_psr_host_model.rd(ADDR_PROTO);
    chk("proto reset", 32'h02, u_psr_host_model.q);
    u_psr_host_model.wr(ADDR_TX_OPT, 8'h55);
    dec(8'h00, PSR_OP_READER, PSR_PR_VIC, 1'b1);
    u_psr_host_model.rd(ADDR_TX_OPT);
    chk("preset", 32'h00, u_psr_host_model.q);
    chk("preset pulse", 32'h1, (pl_seen > 0));
    dec(8'h07, PSR_OP_READER, PSR_PR_VIC, 1'b1);
    dec(8'h08, PSR_OP_READER, PSR_PR_TYPE_A, 1'b1);
    dec(8'h09, PSR_OP_READER, PSR_PR_TYPE_A, 1'b1);
    chk("rate", 32'h1, {30'h0, rs});
    dec(8'h0b, PSR_OP_READER, PSR_PR_TYPE_A, 1'b1);
    dec(8'h0c, PSR_OP_READER, PSR_PR_TYPE_B, 1'b1);
    dec(8'h0f, PSR_OP_READER, PSR_PR_TYPE_B, 1'b1);
    dec(8'h1a, PSR_OP_READER, PSR_PR_PROP, 1'b1);
    dec(8'h1b, PSR_OP_READER, PSR_PR_PROP, 1'b1);
    dec(8'h13, PSR_OP_READER, PSR_PR_NONE, 1'b0);
    dec(8'h14, PSR_OP_READER, PSR_PR_NONE, 1'b0);
    dec(8'h20, PSR_OP_PEER, PSR_PR_NONE, 1'b0);
    dec(8'h21, PSR_OP_PEER, PSR_PR_PEER, 1'b1);
    dec(8'h3b, PSR_OP_PEER, PSR_PR_PEER, 1'b1);
    chk("init act", 32'h3, {init_o, act_o});
    chk("rate", 32'h3, {30'h0, rs});
    dec(8'h24, PSR_OP_EMUL, PSR_PR_TYPE_A, 1'b1);
    dec(8'h25, PSR_OP_EMUL, PSR_PR_TYPE_B, 1'b1);
    dec(8'h26, PSR_OP_EMUL, PSR_PR_NONE, 1'b0);
    u_psr_host_model.wr(ADDR_CMD, CMD_TX_START);
    repeat (3) @(posedge pclk);
    chk("tx refused", 32'h0, tx_seen);
    u_psr_host_model.rd(8'h80);
    chk("unmapped", 32'h1, {31'h0, u_psr_host_model.err});
    u_psr_host_model.wr(ADDR_PROTO, 8'h02);
    // Peak hold: 5 then 2 on main, result keeps 5
    main_c <= 3'h5;
    aux_c <= 3'h4;
    rx_on <= 1'b1;
    u_psr_host_model.setup_meas(8'h20, CMD_INT_LEVEL);
    // The start clears the codes, so the peak must stand inside the window
    repeat (4) @(posedge pclk);
    main_c <= 3'h2;
    u_psr_host_model.rd(ADDR_STATUS);
    chk("busy", 32'h1, u_psr_host_model.q & 32'h1);
    rx_on <= 1'b0;
    u_psr_host_model.pause();
    lvl(8'h65);
    lvl(8'h40);
    rx_on <= 1'b1;
    u_psr_host_model.setup_meas(8'h20, CMD_INT_LEVEL);
    u_psr_host_model.pause();
    // Reception off first, else tracking refills the codes right after the clear
    rx_on <= 1'b0;
    u_psr_host_model.wr(ADDR_CMD, CMD_TX_START);
    repeat (3) @(posedge pclk);
    chk("tx pulse", 32'h1, tx_seen);
    lvl(8'h40);
    ext_c <= 3'h6;
    u_psr_host_model.setup_meas(8'h20, CMD_EXT_LEVEL);
    u_psr_host_model.pause();
    lvl(8'h40);
    u_psr_host_model.setup_meas(8'h02, CMD_EXT_LEVEL);
    u_psr_host_model.pause();
    lvl(8'h46);
    tog(8'h00, 16);
    tog(8'h10, 8);
    tog(8'h20, 4);
    pen <= 1'b0;
    pen2 <= 1'b1;
    tog(8'h00, 4);
    results();
  end
endmodule

// ### dv/psr_host_model.sv
// APB host model that issues register accesses and measurement commands
`timescale 1ns/10ps
module psr_host_model
(
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  logic [31:0] q;
  logic err;

  // Idle bus from time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  // One transfer; request held until pready is sampled high
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // No cycle count assumed; only the bench watchdog ends a stuck wait
      do
        @(posedge pclk);
      while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'h000000, d});
  endtask

  task rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0000_0000);
  endtask

  // Level register must not be read sooner than 50 us after a command
  task pause();
    repeat (12500) @(posedge pclk);
  endtask

  // Transmitter and receiver set before the command is sent
  task setup_meas(input logic [7:0] ctrl, input logic [7:0] cmd);
    wr(8'h00, ctrl);
    wr(8'h40, cmd);
  endtask
endmodule

// ### hw/psr_level_cap.sv
// Peak-hold capture of internal signal level codes and sampling of the external level code
`timescale 1ns/10ps
module psr_level_cap
  import psr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  psr_level_if.cap lv
);
  logic [2:0] main_reg;
  logic [2:0] aux_reg;
  logic [15:0] cnt_reg;
  logic ext_reg;
  logic [2:0] main_next;
  logic [2:0] aux_next;
  // Peak hold: only a larger code replaces the stored one
  assign main_next = (lv.main_code > main_reg) ? lv.main_code : main_reg;
  assign aux_next = (lv.aux_code > aux_reg) ? lv.aux_code : aux_reg;
  assign lv.level = {aux_reg, main_reg};
  assign lv.busy = (cnt_reg != 16'h0000);
  // Clear on transmit or read wins only over tracking; a start or an open window overrides both
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      main_reg <= 3'h0;
      aux_reg <= 3'h0;
      cnt_reg <= 16'h0000;
      ext_reg <= 1'b0;
    end
    else if (lv.start_int || lv.start_ext)
    begin
      main_reg <= 3'h0;
      aux_reg <= 3'h0;
      cnt_reg <= 16'(MEAS_CYCLES);
      ext_reg <= lv.start_ext;
    end
    else if (cnt_reg != 16'h0000)
    begin
      cnt_reg <= cnt_reg - 16'h0001;
      main_reg <= ext_reg ? lv.ext_code : main_next;
      aux_reg <= ext_reg ? 3'h0 : aux_next;
    end
    else if (lv.tx_start || lv.read_clear)
    begin
      main_reg <= 3'h0;
      aux_reg <= 3'h0;
    end
    else if (lv.rx_active)
    begin
      main_reg <= main_next;
      aux_reg <= aux_next;
    end
  end
  peak_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!lv.start_int && !lv.start_ext && !lv.tx_start && !lv.read_clear && !lv.busy)
    |=> main_reg >= $past(main_reg)) else $error("held peak dropped");
  // Transmit start must leave both stored codes at zero when no window is open
  tx_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (lv.tx_start && !lv.busy && !lv.start_int && !lv.start_ext)
    |=> main_reg == 3'h0 && aux_reg == 3'h0) else $error("levels kept over transmit");
endmodule

// ### hw/psr_level_if.sv
// Interface carrying measurement control to and results from the level capture module
`timescale 1ns/10ps
interface psr_level_if;
  logic start_int;
  logic start_ext;
  logic tx_start;
  logic rx_active;
  logic read_clear;
  logic [2:0] main_code;
  logic [2:0] aux_code;
  logic [2:0] ext_code;
  logic [5:0] level;
  logic busy;
  modport ctrl (output start_int, start_ext, tx_start, rx_active, read_clear,
    main_code, aux_code, ext_code, input level, busy);
  modport cap (input start_int, start_ext, tx_start, rx_active, read_clear,
    main_code, aux_code, ext_code, output level, busy);
endinterface

// ### hw/psr_pkg.sv
// Package with register map, field positions, codes and timing for the protocol/level block
// Functional notes
// - Bit 5 picks reader or peer operation
// - Peer bits: initiator, active, card emulation
// - Protocol write reloads timing/option presets
// - Reader codes 0-7 select vicinity protocol
// - Codes 8-15 select type A/B rates
// - 212 code is receive rate when split
// - Codes 26/27 proprietary; 19/20 reserved
// - Peer low bits pick 106/212/424 kbps
// - Emulation low bits pick type A/B
// - Internal level holds peak during reception
// - Transmission start clears stored levels
// - Two 3-bit codes in shared register
// - Chip control bit 1 picks internal/external
// - Commands 0x18/0x19 start level measurements
// - External level samples main input amplitude
// - Level read returns 0x40 to 0x7f
// - Reading level register clears it
// - Bits 5:4 divide clock output 1/2/4
// - Second power-down gives slow clock output
package psr_pkg;
  localparam logic [7:0] ADDR_CHIP_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PROTO = 8'h04;
  localparam logic [7:0] ADDR_TX_OPT = 8'h08;
  localparam logic [7:0] ADDR_HBR_OPT = 8'h0c;
  localparam logic [7:0] ADDR_RX_WAIT = 8'h20;
  localparam logic [7:0] ADDR_MOD_CLK = 8'h24;
  localparam logic [7:0] ADDR_LEVEL = 8'h3c;
  localparam logic [7:0] ADDR_CMD = 8'h40;
  localparam logic [7:0] ADDR_STATUS = 8'h44;
  localparam logic [7:0] ADDR_LEVEL_IN = 8'h48;
  localparam logic [7:0] CMD_INT_LEVEL = 8'h18;
  localparam logic [7:0] CMD_EXT_LEVEL = 8'h19;
  localparam logic [7:0] CMD_TX_START = 8'h11;
  localparam int BIT_PEER = 5;
  localparam int BIT_INIT = 4;
  localparam int BIT_ACTIVE = 3;
  localparam int BIT_EMUL = 2;
  localparam int BIT_LEVEL_SEL = 1;
  localparam int BIT_TX_ON = 5;
  localparam int CLK_DIV_LSB = 4;
  localparam logic [7:0] PROTO_RESET = 8'h02;
  localparam logic [7:0] TX_OPT_PRESET = 8'h00;
  localparam logic [7:0] HBR_OPT_PRESET = 8'h00;
  localparam logic [7:0] MOD_CLK_RESET = 8'h00;
  localparam logic [7:0] LEVEL_BASE = 8'h40;
  localparam int CLK_MHZ = 250;
  localparam int MEAS_TIME_NS = 1000;
  localparam int MEAS_CYCLES = (MEAS_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int SLOW_CLK_HZ = 60000;
  localparam int SLOW_HALF_CYCLES = (CLK_MHZ * 1000000) / (2 * SLOW_CLK_HZ);
  typedef enum logic [1:0] {PSR_OP_READER, PSR_OP_PEER, PSR_OP_EMUL, PSR_OP_NONE} psr_op_t;
  typedef enum logic [2:0]
  {
    PSR_PR_NONE, PSR_PR_VIC, PSR_PR_TYPE_A, PSR_PR_TYPE_B, PSR_PR_PROP, PSR_PR_PEER
  } psr_proto_t;
endpackage

// ### hw/psr_top.sv
// Protocol select decode, level registers and clock output divider with an APB slave
`timescale 1ns/10ps
module psr_top
  import psr_pkg::*;
#(
  parameter int SLOW_HALF = SLOW_HALF_CYCLES
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] main_level_code,
  input wire logic [2:0] aux_level_code,
  input wire logic [2:0] main_rf_input_code,
  input wire logic rx_active,
  input wire logic primary_power_enable,
  input wire logic secondary_power_enable,
  output logic buffered_clock_output,
  output logic framing_enable,
  output psr_pkg::psr_op_t op_mode,
  output psr_pkg::psr_proto_t proto_family,
  output logic [1:0] rate_sel,
  output logic initiator,
  output logic active_mode,
  output logic preset_load,
  output logic tx_start
);
  import psr_pkg::*;
  psr_level_if lv ();
  logic [7:0] chip_reg;
  logic [7:0] proto_reg;
  logic [7:0] txopt_reg;
  logic [7:0] hbr_reg;
  logic [7:0] rxwait_reg;
  logic [7:0] modclk_reg;
  logic [7:0] level_in_reg;
  logic [1:0] div_reg;
  logic [15:0] slow_reg;
  logic clk_out_reg;
  logic [31:0] rdata_next;
  logic wr_en;
  logic rd_en;
  logic mapped;
  logic proto_wr;
  logic cmd_wr;
  logic ext_sel;
  logic slow_mode;
  logic div_tick;
  psr_op_t op_next;
  psr_proto_t fam_next;
  logic [1:0] rate_next;

  // Vicinity protocol coding lookup; 0x02 high rate, one subcarrier, 1-of-4
  function automatic logic [1:0] rate_of(input logic [4:0] c);
    rate_of = c[1:0];
  endfunction

  // Bus strobes
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign mapped = (paddr == ADDR_CHIP_CTRL) || (paddr == ADDR_PROTO) ||
    (paddr == ADDR_TX_OPT) || (paddr == ADDR_HBR_OPT) || (paddr == ADDR_RX_WAIT) ||
    (paddr == ADDR_MOD_CLK) || (paddr == ADDR_LEVEL) || (paddr == ADDR_CMD) ||
    (paddr == ADDR_STATUS) || (paddr == ADDR_LEVEL_IN);
  assign proto_wr = wr_en && (paddr == ADDR_PROTO);
  assign cmd_wr = wr_en && (paddr == ADDR_CMD);
  assign ext_sel = chip_reg[BIT_LEVEL_SEL];

  // Operating mode from bit 5 and bit 2
  assign op_next = !proto_reg[BIT_PEER] ? PSR_OP_READER :
    (proto_reg[BIT_EMUL] ? PSR_OP_EMUL : PSR_OP_PEER);

  // Family decode; anything not listed falls to none and keeps framing idle
  always_comb
  begin
    fam_next = PSR_PR_NONE;
    rate_next = 2'b00;
    case (op_next)
      PSR_OP_READER:
      begin
        if (proto_reg[4:3] == 2'b00)
        begin
          fam_next = PSR_PR_VIC;
          rate_next = rate_of(proto_reg[4:0]);
        end
        else if (proto_reg[4:3] == 2'b01)
        begin
          fam_next = proto_reg[2] ? PSR_PR_TYPE_B : PSR_PR_TYPE_A;
          rate_next = proto_reg[1:0];
        end
        else if (proto_reg[4:1] == 4'b1101)
        begin
          fam_next = PSR_PR_PROP;
          rate_next = proto_reg[1:0];
        end
        else
        begin
          fam_next = PSR_PR_NONE;
        end
      end
      PSR_OP_PEER:
      begin
        fam_next = (proto_reg[1:0] == 2'b00) ? PSR_PR_NONE : PSR_PR_PEER;
        rate_next = proto_reg[1:0];
      end
      PSR_OP_EMUL:
      begin
        fam_next = proto_reg[1] ? PSR_PR_NONE :
          (proto_reg[0] ? PSR_PR_TYPE_B : PSR_PR_TYPE_A);
        rate_next = 2'b00;
      end
      default:
      begin
        fam_next = PSR_PR_NONE;
        rate_next = 2'b00;
      end
    endcase
  end

  // Level channel wiring
  assign lv.start_int = cmd_wr && (pwdata[7:0] == CMD_INT_LEVEL);
  assign lv.start_ext = cmd_wr && (pwdata[7:0] == CMD_EXT_LEVEL) && ext_sel;
  assign lv.tx_start = cmd_wr && (pwdata[7:0] == CMD_TX_START);
  assign lv.rx_active = rx_active && chip_reg[BIT_TX_ON];
  assign lv.read_clear = rd_en && (paddr == ADDR_LEVEL);
  assign lv.main_code = main_level_code;
  assign lv.aux_code = aux_level_code;
  assign lv.ext_code = main_rf_input_code;

  psr_level_cap u_cap (
    .pclk(pclk),
    .presetn(presetn),
    .lv(lv)
  );

  // Read mux; level always reads with bit 6 set
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    case (paddr)
      ADDR_CHIP_CTRL: rdata_next = {24'h0, chip_reg};
      ADDR_PROTO: rdata_next = {24'h0, proto_reg};
      ADDR_TX_OPT: rdata_next = {24'h0, txopt_reg};
      ADDR_HBR_OPT: rdata_next = {24'h0, hbr_reg};
      ADDR_RX_WAIT: rdata_next = {24'h0, rxwait_reg};
      ADDR_MOD_CLK: rdata_next = {24'h0, modclk_reg};
      ADDR_LEVEL: rdata_next = {24'h0, LEVEL_BASE | {2'b00, lv.level}};
      ADDR_STATUS: rdata_next = {31'h0, lv.busy};
      ADDR_LEVEL_IN: rdata_next = {24'h0, level_in_reg};
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  // Register writes; protocol write reloads presets so later tuning sticks
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      chip_reg <= 8'h00;
      proto_reg <= PROTO_RESET;
      txopt_reg <= TX_OPT_PRESET;
      hbr_reg <= HBR_OPT_PRESET;
      rxwait_reg <= 8'h00;
      modclk_reg <= MOD_CLK_RESET;
      level_in_reg <= 8'h00;
    end
    else if (wr_en)
    begin
      case (paddr)
        ADDR_CHIP_CTRL: chip_reg <= pwdata[7:0];
        ADDR_PROTO:
        begin
          proto_reg <= pwdata[7:0];
          txopt_reg <= TX_OPT_PRESET;
          hbr_reg <= HBR_OPT_PRESET;
          rxwait_reg <= 8'h00;
        end
        ADDR_TX_OPT: txopt_reg <= pwdata[7:0];
        ADDR_HBR_OPT: hbr_reg <= pwdata[7:0];
        ADDR_RX_WAIT: rxwait_reg <= pwdata[7:0];
        ADDR_MOD_CLK: modclk_reg <= pwdata[7:0];
        ADDR_LEVEL_IN: level_in_reg <= pwdata[7:0];
        default: level_in_reg <= level_in_reg;
      endcase
    end
  end

  // Bus answer in the first access cycle; unmapped addresses flag an error
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= rdata_next;
    end
  end

  // Registered decode outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      op_mode <= PSR_OP_READER;
      proto_family <= PSR_PR_VIC;
      rate_sel <= 2'b10;
      initiator <= 1'b0;
      active_mode <= 1'b0;
      framing_enable <= 1'b1;
      preset_load <= 1'b0;
      tx_start <= 1'b0;
    end
    else
    begin
      op_mode <= op_next;
      proto_family <= fam_next;
      rate_sel <= rate_next;
      initiator <= proto_reg[BIT_PEER] && proto_reg[BIT_INIT];
      active_mode <= proto_reg[BIT_PEER] && proto_reg[BIT_ACTIVE];
      framing_enable <= (fam_next != PSR_PR_NONE);
      preset_load <= proto_wr;
      tx_start <= lv.tx_start && (fam_next != PSR_PR_NONE);
    end
  end

  // Clock output divider; slow mode from a long counter
  assign slow_mode = !primary_power_enable && secondary_power_enable;
  assign div_tick = slow_mode ? (slow_reg == 16'h0000) :
    (modclk_reg[CLK_DIV_LSB+1:CLK_DIV_LSB] == 2'b00) || (div_reg == 2'b00);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_reg <= 2'b00;
      slow_reg <= 16'h0000;
      clk_out_reg <= 1'b0;
    end
    else
    begin
      slow_reg <= (slow_reg == 16'h0000) ? 16'(SLOW_HALF - 1) : slow_reg - 16'h0001;
      // Free wrap at 4 for the /4 setting; masked to wrap at 2 for /2, held at 0 for /1
      div_reg <= modclk_reg[CLK_DIV_LSB+1] ? div_reg + 2'b01 :
        (div_reg + 2'b01) & {1'b0, modclk_reg[CLK_DIV_LSB]};
      if (div_tick)
        clk_out_reg <= !clk_out_reg;
    end
  end
  assign buffered_clock_output = clk_out_reg;

  level_range_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && paddr == ADDR_LEVEL) |=> prdata[7:6] == 2'b01)
    else $error("level read out of range");
  reserved_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!proto_reg[BIT_PEER] && proto_reg[4:0] == 5'b10011) |=> !framing_enable)
    else $error("reserved code enabled framing");
  preset_reload_a: assert property (@(posedge pclk) disable iff (!presetn)
    proto_wr |=> txopt_reg == TX_OPT_PRESET && hbr_reg == HBR_OPT_PRESET)
    else $error("presets not reloaded");
  read_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (lv.read_clear && !lv.busy && !lv.start_int && !lv.start_ext) |=> lv.level == 6'h00)
    else $error("level not cleared by read");
endmodule
